// ### hw/dma_pkg.sv
// Purpose: Shared constants of the two-channel transfer engine.
// Assumes: Registers are 32-bit Avalon-MM words at byte addresses.
// Notes:   Field positions index the channel control word and the bus configuration word.
package dma_pkg;
  localparam int CH_N   = 2;
  localparam int ADDR_W = 20;
  localparam int CNT_W  = 16;
  localparam int SEL_W  = 3;
  localparam int SRC_N  = 8;
  localparam int AV_AW  = 7;

  localparam logic [AV_AW-1:0] OFS_CTRL   = 7'h00;
  localparam logic [AV_AW-1:0] OFS_SEL    = 7'h04;
  localparam logic [AV_AW-1:0] OFS_SRC    = 7'h08;
  localparam logic [AV_AW-1:0] OFS_DST    = 7'h0c;
  localparam logic [AV_AW-1:0] OFS_CNT    = 7'h10;
  localparam logic [AV_AW-1:0] OFS_BUSCFG = 7'h40;
  localparam logic [AV_AW-1:0] OFS_STATUS = 7'h44;
  localparam logic [AV_AW-1:0] CH_SPAN    = 7'h20;

  localparam int CTRL_EN      = 0;
  localparam int CTRL_UNIT8   = 1;
  localparam int CTRL_SRC_FWD = 2;
  localparam int CTRL_DST_FWD = 3;
  localparam int CTRL_RPT     = 4;
  localparam int CTRL_REQ     = 5;
  localparam int CTRL_SWTRIG  = 6;

  localparam int CFG_BUS16   = 0;
  localparam int CFG_WAIT_LO = 1;
  localparam int CFG_WAIT_HI = 3;

  localparam logic       RST_BUS16 = 1'h1;
  localparam logic [1:0] RST_WAIT  = 2'h0;
  localparam logic [ADDR_W-1:0] REGION_BOUND = 20'h00400;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10,
    ST_BACK  = 2'b11
  } st_e;
endpackage

// ### hw/dma_req_latch.sv
// Purpose: One channel's request flag with its own set of sources.
// Assumes: Sources are same-clock levels; a rising edge is a request.
// Notes:   A request in the clearing cycle is kept.
module dma_req_latch #(
  parameter int N     = 8,
  parameter int SEL_W = 3
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic [N-1:0]     i_sources,
  input  wire logic [SEL_W-1:0] i_sel,
  input  wire logic             i_sw_trig,
  input  wire logic             i_clear,
  input  wire logic             i_take,
  output logic                  o_pending
);
  if (N > (1 << SEL_W)) begin : g_chk
    $error("Source count exceeds selector width.");
  end

  typedef struct packed {
    logic         pending;
    logic [N-1:0] prev;
  } req_s;

  req_s s;
  req_s next_s;
  logic event_now;

  always_comb begin
    event_now = i_sw_trig | (i_sources[i_sel] & ~s.prev[i_sel]);
    next_s.prev = i_sources;
    next_s.pending = event_now | (s.pending & ~i_clear & ~i_take);
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_pending = s.pending;
endmodule

// ### hw/dma_engine.sv
// Purpose: Two-channel transfer engine with an Avalon-MM register slave.
// Assumes: The CPU releases the bus to the engine while hold is high.
// Notes:   A unit is a source read phase then a destination write phase.
// Contract
// - On reload, forward pointer and counter take their stored start values.
// - Transfers ignore every interrupt mask and interrupt setting.
// - Each channel selects among its own, different request sources.
// - A unit is a source read bus cycle then a destination write.
// - Bus cycles stretch by software waits and the ready-wait input.
// - Odd source, 16-bit unit and bus: one more read bus cycle.
// - Odd destination, 16-bit unit and bus: one more write bus cycle.
// - Each access adds the wait states configured for its region.
// - 16-bit units over an 8-bit bus take two reads and two writes.
// - Repeat mode reloads on underflow until the enable bit is cleared.
// - The first transfer after enabling reloads the counter.
// - Simultaneous requests grant channel 0 before channel 1.
// - After a unit the bus returns to the CPU for one access.
module dma_engine
  import dma_pkg::*;
(
  input  wire logic                       I_CLOCK,
  input  wire logic                       I_RST_N,
  input  wire logic [dma_pkg::AV_AW-1:0]  I_AVS_ADDRESS,
  input  wire logic                       I_AVS_READ,
  input  wire logic                       I_AVS_WRITE,
  input  wire logic [31:0]                I_AVS_WRITEDATA,
  output logic      [31:0]                O_AVS_READDATA,
  output logic                            O_AVS_WAITREQUEST,
  input  wire logic [2*dma_pkg::SRC_N-1:0] I_REQ_SRC,
  input  wire logic                       I_CPU_DONE,
  input  wire logic                       I_RDY_N,
  input  wire logic [15:0]                I_BUS_RDATA,
  output logic      [dma_pkg::ADDR_W-1:0] O_BUS_ADDR,
  output logic                            O_BUS_RD,
  output logic                            O_BUS_WR,
  output logic                            O_BUS_WIDE,
  output logic      [15:0]                O_BUS_WDATA,
  output logic                            O_BUS_HOLD
);
  import dma_pkg::*;
  typedef struct packed {
    logic                          waitreq;
    logic [31:0]                   rdata;
    logic [2:0]                    rdy_q;
    logic                          rdy_n;
    logic [CH_N-1:0]               en;
    logic [CH_N-1:0]               unit8;
    logic [CH_N-1:0]               src_fwd;
    logic [CH_N-1:0]               dst_fwd;
    logic [CH_N-1:0]               rpt;
    logic [CH_N-1:0]               reload_pend;
    logic [CH_N-1:0][SEL_W-1:0]    sel;
    logic [CH_N-1:0][ADDR_W-1:0]   src;
    logic [CH_N-1:0][ADDR_W-1:0]   dst;
    logic [CH_N-1:0][ADDR_W-1:0]   fwd;
    logic [CH_N-1:0][CNT_W-1:0]    cnt_rl;
    logic [CH_N-1:0][CNT_W-1:0]    cnt;
    logic                          bus16;
    logic [1:0]                    wait_lo;
    logic [1:0]                    wait_hi;
    st_e                           st;
    logic                          ch;
    logic                          sub;
    logic                          two;
    logic [1:0]                    wcnt;
    logic [15:0]                   data;
    logic [ADDR_W-1:0]             bus_addr;
    logic                          bus_rd;
    logic                          bus_wr;
    logic                          bus_wide;
    logic [15:0]                   bus_wdata;
    logic                          hold;
  } eng_s;
  eng_s               s;
  eng_s               next_s;
  logic [CH_N-1:0]    pending;
  logic [CH_N-1:0]    sw_trig;
  logic [CH_N-1:0]    clr_req;
  logic [CH_N-1:0]    take;
  // Two bus cycles when a 16-bit unit meets an odd address or an 8-bit bus.
  function automatic logic two_cycles(input logic unit8, input logic bus16,
                                      input logic [ADDR_W-1:0] addr);
    return !unit8 && (!bus16 || addr[0]);
  endfunction
  function automatic logic [1:0] waits(input logic [ADDR_W-1:0] addr,
                                       input logic [1:0] lo,
                                       input logic [1:0] hi);
    return (addr < REGION_BOUND) ? lo : hi;
  endfunction
  function automatic logic [AV_AW-1:0] reg_off(input logic [AV_AW-1:0] a);
    return (a < OFS_BUSCFG) ? (a & (CH_SPAN - 7'h01)) : a;
  endfunction
  genvar g;
  for (g = 0; g < CH_N; g++) begin : g_req
    dma_req_latch #(.N(SRC_N), .SEL_W(SEL_W)) u_req (
      .i_clock   (I_CLOCK),
      .i_rst_n   (I_RST_N),
      .i_sources (I_REQ_SRC[g*SRC_N +: SRC_N]),
      .i_sel     (s.sel[g]),
      .i_sw_trig (sw_trig[g]),
      .i_clear   (clr_req[g]),
      .i_take    (take[g]),
      .o_pending (pending[g])
    );
  end
  always_comb begin
    logic                 c;
    logic                 cw;
    logic [AV_AW-1:0]     off;
    logic [ADDR_W-1:0]    a;
    logic [ADDR_W-1:0]    cur_fwd;
    logic [CNT_W-1:0]     cur_cnt;
    logic [31:0]          rv;
    logic [CH_N-1:0]      ready;
    c = 1'b0;
    cw = I_AVS_ADDRESS[5];
    off = reg_off(I_AVS_ADDRESS);
    a = '0;
    cur_fwd = '0;
    cur_cnt = '0;
    rv = '0;
    ready = pending & s.en;
    next_s = s;
    take = '0;
    sw_trig = '0;
    clr_req = '0;
    next_s.rdy_q = {s.rdy_q[1:0], I_RDY_N};
    if (s.rdy_q[1] == s.rdy_q[2]) begin
      next_s.rdy_n = s.rdy_q[2];
    end
    case (s.st)
      ST_IDLE: begin
        if (ready != '0) begin
          c = !ready[0];
          take[c] = 1'b1;
          cur_fwd = s.fwd[c];
          cur_cnt = s.cnt[c];
          if (s.reload_pend[c]) begin
            cur_fwd = s.src_fwd[c] ? s.src[c] : s.dst[c];
            cur_cnt = s.cnt_rl[c];
            next_s.reload_pend[c] = 1'b0;
          end
          next_s.fwd[c] = cur_fwd;
          next_s.cnt[c] = cur_cnt;
          a = s.src_fwd[c] ? cur_fwd : s.src[c];
          next_s.ch = c;
          next_s.st = ST_READ;
          next_s.sub = 1'b0;
          next_s.two = two_cycles(s.unit8[c], s.bus16, a);
          next_s.wcnt = waits(a, s.wait_lo, s.wait_hi);
          next_s.bus_addr = a;
          next_s.bus_wide = s.bus16 && !s.unit8[c] && !a[0];
          next_s.bus_rd = 1'b1;
          next_s.hold = 1'b1;
        end
      end
      ST_READ: begin
        c = s.ch;
        if (s.wcnt != 2'h0) begin
          next_s.wcnt = s.wcnt - 2'h1;
        end else if (!s.rdy_n) begin
          if (s.two && !s.sub) begin
            next_s.data[7:0] = I_BUS_RDATA[7:0];
            next_s.sub = 1'b1;
            next_s.bus_addr = s.bus_addr + ADDR_W'(1);
            next_s.wcnt = waits(next_s.bus_addr, s.wait_lo, s.wait_hi);
          end else begin
            if (s.two) begin
              next_s.data[15:8] = I_BUS_RDATA[7:0];
            end else begin
              next_s.data = I_BUS_RDATA;
            end
            a = s.dst_fwd[c] ? s.fwd[c] : s.dst[c];
            next_s.st = ST_WRITE;
            next_s.sub = 1'b0;
            next_s.two = two_cycles(s.unit8[c], s.bus16, a);
            next_s.wcnt = waits(a, s.wait_lo, s.wait_hi);
            next_s.bus_addr = a;
            next_s.bus_wide = s.bus16 && !s.unit8[c] && !a[0];
            next_s.bus_rd = 1'b0;
            next_s.bus_wr = 1'b1;
            next_s.bus_wdata = next_s.two ? {8'h00, next_s.data[7:0]}
                                          : next_s.data;
          end
        end
      end
      ST_WRITE: begin
        c = s.ch;
        if (s.wcnt != 2'h0) begin
          next_s.wcnt = s.wcnt - 2'h1;
        end else if (!s.rdy_n) begin
          if (s.two && !s.sub) begin
            next_s.sub = 1'b1;
            next_s.bus_addr = s.bus_addr + ADDR_W'(1);
            next_s.bus_wdata = {8'h00, s.data[15:8]};
            next_s.wcnt = waits(next_s.bus_addr, s.wait_lo, s.wait_hi);
          end else begin
            next_s.fwd[c] = s.fwd[c] + (s.unit8[c] ? ADDR_W'(1)
                                                    : ADDR_W'(2));
            next_s.cnt[c] = s.cnt[c] - CNT_W'(1);
            if (s.cnt[c] == '0) begin
              if (s.rpt[c]) begin
                next_s.fwd[c] = s.src_fwd[c] ? s.src[c] : s.dst[c];
                next_s.cnt[c] = s.cnt_rl[c];
              end else begin
                next_s.en[c] = 1'b0;
              end
            end
            next_s.bus_wr = 1'b0;
            next_s.bus_wide = 1'b0;
            next_s.hold = 1'b0;
            next_s.st = ST_BACK;
          end
        end
      end
      ST_BACK: begin
        if (I_CPU_DONE) begin
          next_s.st = ST_IDLE;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
    if (off == OFS_STATUS) begin
      rv = {29'h0, s.st, s.ch};
    end else if (off == OFS_BUSCFG) begin
      rv = {27'h0, s.wait_hi, s.wait_lo, s.bus16};
    end else if (I_AVS_ADDRESS < OFS_BUSCFG) begin
      case (off)
        OFS_CTRL: rv = {26'h0, pending[cw], s.rpt[cw], s.dst_fwd[cw],
                        s.src_fwd[cw], s.unit8[cw], s.en[cw]};
        OFS_SEL: rv = {{(32-SEL_W){1'b0}}, s.sel[cw]};
        OFS_SRC: rv = {{(32-ADDR_W){1'b0}}, s.src[cw]};
        OFS_DST: rv = {{(32-ADDR_W){1'b0}}, s.dst[cw]};
        OFS_CNT: rv = {{(32-CNT_W){1'b0}}, s.cnt[cw]};
        default: rv = '0;
      endcase
    end
    if ((I_AVS_READ || I_AVS_WRITE) && s.waitreq) begin
      next_s.waitreq = 1'b0;
      next_s.rdata = rv;
    end else begin
      next_s.waitreq = 1'b1;
    end
    if (I_AVS_WRITE && !s.waitreq) begin
      if (off == OFS_BUSCFG) begin
        next_s.bus16 = I_AVS_WRITEDATA[CFG_BUS16];
        next_s.wait_lo = I_AVS_WRITEDATA[CFG_WAIT_LO +: 2];
        next_s.wait_hi = I_AVS_WRITEDATA[CFG_WAIT_HI +: 2];
      end else if (I_AVS_ADDRESS < OFS_BUSCFG) begin
        case (off)
          OFS_CTRL: begin
            next_s.en[cw] = I_AVS_WRITEDATA[CTRL_EN];
            next_s.reload_pend[cw] = I_AVS_WRITEDATA[CTRL_EN] |
                                     next_s.reload_pend[cw];
            next_s.unit8[cw] = I_AVS_WRITEDATA[CTRL_UNIT8];
            next_s.src_fwd[cw] = I_AVS_WRITEDATA[CTRL_SRC_FWD];
            next_s.dst_fwd[cw] = I_AVS_WRITEDATA[CTRL_DST_FWD];
            next_s.rpt[cw] = I_AVS_WRITEDATA[CTRL_RPT];
            clr_req[cw] = !I_AVS_WRITEDATA[CTRL_REQ];
            sw_trig[cw] = I_AVS_WRITEDATA[CTRL_SWTRIG];
          end
          OFS_SEL: next_s.sel[cw] = I_AVS_WRITEDATA[SEL_W-1:0];
          OFS_SRC: next_s.src[cw] = I_AVS_WRITEDATA[ADDR_W-1:0];
          OFS_DST: next_s.dst[cw] = I_AVS_WRITEDATA[ADDR_W-1:0];
          OFS_CNT: next_s.cnt_rl[cw] = I_AVS_WRITEDATA[CNT_W-1:0];
          default: next_s.cnt_rl[cw] = s.cnt_rl[cw];
        endcase
      end
    end
  end
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      s <= '0;
      s.waitreq <= 1'b1;
      s.rdy_q <= 3'h7;
      s.rdy_n <= 1'b1;
      s.bus16 <= RST_BUS16;
      s.wait_lo <= RST_WAIT;
      s.wait_hi <= RST_WAIT;
      s.st <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end
  assign O_AVS_READDATA = s.rdata;
  assign O_AVS_WAITREQUEST = s.waitreq;
  assign O_BUS_ADDR = s.bus_addr;
  assign O_BUS_RD = s.bus_rd;
  assign O_BUS_WR = s.bus_wr;
  assign O_BUS_WIDE = s.bus_wide;
  assign O_BUS_WDATA = s.bus_wdata;
  assign O_BUS_HOLD = s.hold;
endmodule

// ### verification/dma_engine_asserts.sv
// Purpose: Concurrent checks on the engine's transfer bus.
// Assumes: Sees only the engine's top ports.
// Notes:   Bound into every engine instance.
module dma_engine_asserts
  import dma_pkg::*;
(
  input wire logic                       I_CLOCK,
  input wire logic                       I_RST_N,
  input wire logic                       I_RDY_N,
  input wire logic                       I_CPU_DONE,
  input wire logic [dma_pkg::ADDR_W-1:0] O_BUS_ADDR,
  input wire logic                       O_BUS_RD,
  input wire logic                       O_BUS_WR,
  input wire logic                       O_BUS_WIDE,
  input wire logic                       O_BUS_HOLD
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);
  property p_rw_apart;
    !(O_BUS_RD && O_BUS_WR);
  endproperty
  a_rw_apart: assert property (p_rw_apart)
    else $error("read and write strobes high together");
  property p_read_first;
    $rose(O_BUS_HOLD) |-> O_BUS_RD && !O_BUS_WR;
  endproperty
  a_read_first: assert property (p_read_first)
    else $error("unit did not open with a read");
  property p_write_follows;
    $fell(O_BUS_RD) |-> O_BUS_WR && O_BUS_HOLD;
  endproperty
  a_write_follows: assert property (p_write_follows)
    else $error("read phase not followed by a write");
  property p_hold_owns;
    O_BUS_RD || O_BUS_WR |-> O_BUS_HOLD;
  endproperty
  a_hold_owns: assert property (p_hold_owns)
    else $error("bus strobe without bus ownership");
  property p_hand_back;
    $fell(O_BUS_WR) |-> !O_BUS_HOLD && !O_BUS_RD;
  endproperty
  a_hand_back: assert property (p_hand_back)
    else $error("bus kept after the write phase");
  property p_back_wait;
    $fell(O_BUS_HOLD) && !I_CPU_DONE |=> !O_BUS_HOLD;
  endproperty
  a_back_wait: assert property (p_back_wait)
    else $error("bus taken again before a CPU access");
  property p_wide_even;
    O_BUS_WIDE && (O_BUS_RD || O_BUS_WR) |-> !O_BUS_ADDR[0];
  endproperty
  a_wide_even: assert property (p_wide_even)
    else $error("wide access at an odd address");
  property p_stretch;
    I_RDY_N [*5] ##0 O_BUS_RD |=> O_BUS_RD && $stable(O_BUS_ADDR);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("read ended while not ready");
endmodule
bind dma_engine dma_engine_asserts i_dma_engine_asserts (
  .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_RDY_N(I_RDY_N),
  .I_CPU_DONE(I_CPU_DONE), .O_BUS_ADDR(O_BUS_ADDR), .O_BUS_RD(O_BUS_RD),
  .O_BUS_WR(O_BUS_WR), .O_BUS_WIDE(O_BUS_WIDE), .O_BUS_HOLD(O_BUS_HOLD));

// ### verification/dma_mem_model.sv
// Purpose: Memory, peripheral and CPU side of the transfer bus.
// Assumes: Byte accesses use lane [7:0].
// Notes:   Counts clocks with read or write strobe high.
module dma_mem_model
  import dma_pkg::*;
(
  input  wire logic                       i_clock,
  input  wire logic [dma_pkg::ADDR_W-1:0] i_addr,
  input  wire logic                       i_rd,
  input  wire logic                       i_wr,
  input  wire logic                       i_wide,
  input  wire logic                       i_hold,
  input  wire logic [15:0]                i_wdata,
  input  wire logic                       i_stretch,
  input  wire logic                       i_clear,
  output logic      [15:0]                o_rdata,
  output logic                            o_rdy_n,
  output logic                            o_cpu_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]        mem [256];
  logic [7:0]        a;
  logic [7:0]        a1;
  logic [3:0]        idle = 4'hf;
  logic              flip = 1'b0;
  logic              rd_q = 1'b0;
  int                rd_clk = 0;
  int                wr_clk = 0;
  logic [ADDR_W-1:0] rd_addr = '0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  assign a = i_addr[7:0];
  assign a1 = a + 8'h1;
  // Idle lanes show a pattern that flips every cycle.
  assign o_rdata = !i_rd ? {16{flip}} :
                   {i_wide ? mem[a1] : {8{flip}}, mem[a]};
  assign o_rdy_n = i_stretch;
  assign o_cpu_done = (idle == 4'h2);
  always @(posedge i_clock) begin
    flip <= ~flip;
    rd_q <= i_rd;
    idle <= i_hold ? 4'h0 : (idle == 4'hf ? idle : idle + 4'h1);
    rd_clk <= i_clear ? 0 : rd_clk + int'(i_rd);
    wr_clk <= i_clear ? 0 : wr_clk + int'(i_wr);
    if (i_rd && !rd_q) rd_addr <= i_addr;
    if (i_wr) mem[a] <= i_wdata[7:0];
    if (i_wr && i_wide) mem[a1] <= i_wdata[15:8];
  end
endmodule

// ### verification/testbench.sv
// Purpose: Self-checking bench for the two-channel transfer engine.
// Assumes: Pointers stay below the engine's own registers.
// Notes:   The transfer bus partner is dma_mem_model.
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
      bad_count++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module testbench
  import dma_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [6:0]        av_addr = '0;
  logic              av_rd = 1'b0;
  logic              av_wr = 1'b0;
  logic [31:0]       av_wdata = '0;
  logic [31:0]       rdata;
  logic              waitreq;
  logic [15:0]       req_src = '0;
  logic              stretch = 1'b0;
  logic              clr = 1'b0;
  logic              cpu_done, rdy_n, bus_rd, bus_wr, bus_wide, hold;
  logic [15:0]       bus_rdata, bus_wdata;
  logic [ADDR_W-1:0] bus_addr;
  int                bad_count = 0;
  int                num_checks = 0;
  always #12.5 clk = ~clk;
  dma_engine i_dma_engine (.I_CLOCK(clk), .I_RST_N(rst_n),
    .I_AVS_ADDRESS(av_addr), .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr),
    .I_AVS_WRITEDATA(av_wdata), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(waitreq), .I_REQ_SRC(req_src),
    .I_CPU_DONE(cpu_done), .I_RDY_N(rdy_n), .I_BUS_RDATA(bus_rdata),
    .O_BUS_ADDR(bus_addr), .O_BUS_RD(bus_rd), .O_BUS_WR(bus_wr),
    .O_BUS_WIDE(bus_wide), .O_BUS_WDATA(bus_wdata), .O_BUS_HOLD(hold));
  dma_mem_model i_dma_mem_model (.i_clock(clk), .i_addr(bus_addr),
    .i_rd(bus_rd), .i_wr(bus_wr), .i_wide(bus_wide), .i_hold(hold),
    .i_wdata(bus_wdata), .i_stretch(stretch), .i_clear(clr),
    .o_rdata(bus_rdata), .o_rdy_n(rdy_n), .o_cpu_done(cpu_done));
  task automatic av(input logic w, input logic [6:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    av_addr <= a;
    av_wdata <= d;
    av_wr <= w;
    av_rd <= !w;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic reg_wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask
  task automatic reg_chk(input logic [6:0] a, input logic [31:0] ex);
    logic [31:0] q;
    av(1'b0, a, '0, q);
    `CHK("register", ex, q)
  endtask
  task automatic pulse(input logic [15:0] v);
    req_src <= v;
    @(posedge clk);
    req_src <= '0;
    @(posedge clk);
  endtask
  task automatic wait_unit();
    for (int n = 0; n < 80 && hold !== 1'b1; n++) @(posedge clk);
    for (int n = 0; n < 80 && hold !== 1'b0; n++) @(posedge clk);
  endtask
  task automatic regs_reset();
    `CHK("hold", 1'b0, hold)
    reg_chk(OFS_BUSCFG, 32'h1);
    reg_wr(7'h7c, 32'hffffffff);
    reg_chk(7'h7c, 32'h0);
  endtask
  task automatic cycle_table();
    logic [39:0] e;
    logic [39:0] tbl [6] = '{40'h1011002011, 40'h0011002011,
      40'h0011102021, 40'h0011002112, 40'h0001002022, 40'h10d1042032};
    for (int i = 0; i < 6; i++) begin
      e = tbl[i];
      clr <= 1'b1;
      reg_wr(OFS_BUSCFG, {24'h0, e[35:28]});
      clr <= 1'b0;
      reg_wr(OFS_SRC, {24'h0, e[27:20]});
      reg_wr(OFS_DST, {20'h0, e[19:8]});
      reg_wr(OFS_CNT, 32'h0);
      i_dma_mem_model.mem[e[15:8]] <= 8'h00;
      reg_wr(OFS_CTRL, 32'h49 | {30'h0, e[36], 1'b0});
      wait_unit();
      `CHK("reads", int'(e[7:4]), i_dma_mem_model.rd_clk)
      `CHK("writes", int'(e[3:0]), i_dma_mem_model.wr_clk)
      `CHK("data", e[27:20] ^ 8'h5a, i_dma_mem_model.mem[e[15:8]])
    end
  endtask
  task automatic reload_check();
    reg_wr(OFS_BUSCFG, 32'h1);
    reg_wr(OFS_SEL, 32'h0);
    reg_wr(OFS_SRC, 32'h30);
    reg_wr(OFS_DST, 32'h40);
    reg_wr(OFS_CNT, 32'h3);
    reg_wr(OFS_CTRL, 32'h47);
    wait_unit();
    `CHK("source", 20'h30, i_dma_mem_model.rd_addr)
    reg_chk(OFS_CNT, 32'h2);
    pulse(16'h1);
    wait_unit();
    `CHK("source", 20'h31, i_dma_mem_model.rd_addr)
    reg_chk(OFS_CNT, 32'h1);
    reg_wr(OFS_CTRL, 32'h47);
    wait_unit();
    `CHK("source", 20'h30, i_dma_mem_model.rd_addr)
    reg_chk(OFS_CNT, 32'h2);
  endtask
  task automatic prio_repeat();
    logic [31:0] q;
    reg_wr(OFS_CNT, 32'h0);
    reg_wr(CH_SPAN + OFS_SEL, 32'h2);
    reg_wr(CH_SPAN + OFS_SRC, 32'h50);
    reg_wr(CH_SPAN + OFS_DST, 32'h60);
    reg_wr(CH_SPAN + OFS_CNT, 32'h0);
    reg_wr(OFS_CTRL, 32'h17);
    reg_wr(CH_SPAN + OFS_CTRL, 32'h17);
    pulse(16'h0401);
    wait_unit();
    `CHK("first grant", 20'h30, i_dma_mem_model.rd_addr)
    wait_unit();
    `CHK("second grant", 20'h50, i_dma_mem_model.rd_addr)
    av(1'b0, OFS_CTRL, '0, q);
    `CHK("enable kept", 1'b1, q[CTRL_EN])
    clr <= 1'b1;
    reg_wr(OFS_CTRL, 32'h0);
    clr <= 1'b0;
    pulse(16'h0005);
    repeat (10) @(posedge clk);
    `CHK("no transfer", 0, i_dma_mem_model.rd_clk)
  endtask
  task automatic stretch_check();
    stretch <= 1'b1;
    repeat (4) @(posedge clk);
    reg_wr(OFS_CTRL, 32'h47);
    for (int n = 0; n < 40 && bus_rd !== 1'b1; n++) @(posedge clk);
    repeat (8) @(posedge clk);
    `CHK("stretched read", 1'b1, bus_rd)
    stretch <= 1'b0;
    wait_unit();
    `CHK("unit ended", 1'b0, hold)
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    regs_reset();
    cycle_table();
    reload_check();
    prio_repeat();
    stretch_check();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule
